// *** latency_controller.sv ***
`timescale 1ns/1ps
// apb-programmed controller that issues mode-register and write commands
module latency_controller
  import latency_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  mode_link_if.controller  link
);
  logic [31:0] addr_r, addr_nxt;
  logic [7:0]  rd_r, rd_nxt;
  logic        lev_r, lev_nxt, err_r, err_nxt;
  cmd_t        cmd_r, cmd_nxt;
  logic [5:0]  ma_r, ma_nxt;
  logic [7:0]  wd_r, wd_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic        bl_r, bl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        wr_acc, rd_acc, go;

  assign wr_acc = psel && penable && pwrite;
  // read data loads in the setup cycle, so it already stands at the access edge
  assign rd_acc = psel && !penable && !pwrite;
  assign go     = wr_acc && (paddr == CTRL_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr > STATUS_OFF) && (paddr != LAT_OFF);
  assign prdata  = prdata_r;
  assign link.cmd = cmd_r;
  assign link.ma = ma_r;
  assign link.wdata = wd_r;
  assign link.col = col_r;
  assign link.bl32 = bl_r;
  assign link.beat_valid = 1'b0;

  // ctrl write: [1:0] command, [2] bl32; addr: [5:0] ma, [15:8] data, [25:20] column bits 9:4
  always_comb begin
    addr_nxt = addr_r;
    rd_nxt   = rd_r;
    lev_nxt  = lev_r;
    err_nxt  = err_r | link.cmd_err;
    cmd_nxt  = CMD_NONE;
    ma_nxt   = ma_r;
    wd_nxt   = wd_r;
    col_nxt  = col_r;
    bl_nxt   = bl_r;
    prdata_nxt = prdata_r;
    if (link.rvalid) begin
      rd_nxt = link.rdata;
    end
    if (wr_acc && paddr == ADDR_OFF) begin
      addr_nxt = pwdata;
    end
    if (wr_acc && paddr == STATUS_OFF) begin
      err_nxt = link.cmd_err; // new error wins over clear
    end
    if (go) begin
      // while leveling only the clearing latency write may go out
      if (!lev_r || (cmd_t'(pwdata[1:0]) == CMD_MRW && addr_r[5:0] == LATENCY_CONFIG_MA)) begin
        cmd_nxt  = cmd_t'(pwdata[1:0]);
        ma_nxt   = addr_r[5:0];
        wd_nxt   = addr_r[15:8];
        // a 32-beat write starts on a 32-beat boundary: column bit 4 cleared
        col_nxt  = {addr_r[25:21], pwdata[2] ? 1'b0 : addr_r[20], 4'h0};
        bl_nxt   = pwdata[2];
        if (cmd_t'(pwdata[1:0]) == CMD_MRW && addr_r[5:0] == LATENCY_CONFIG_MA) begin
          lev_nxt = addr_r[8+WRLEV_BIT];
        end
      end else begin
        err_nxt = 1'b1;
      end
    end
    if (rd_acc) begin
      case (paddr)
        ADDR_OFF:   prdata_nxt = addr_r;
        STATUS_OFF: prdata_nxt = {22'h0, err_r, lev_r, rd_r};
        default:    prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 32'h0000_0000;
      rd_r <= 8'h00;
      lev_r <= 1'b0;
      err_r <= 1'b0;
      cmd_r <= CMD_NONE;
      ma_r <= 6'h00;
      wd_r <= 8'h00;
      col_r <= '0;
      bl_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      lev_r <= lev_nxt;
      err_r <= err_nxt;
      cmd_r <= cmd_nxt;
      ma_r <= ma_nxt;
      wd_r <= wd_nxt;
      col_r <= col_nxt;
      bl_r <= bl_nxt;
      prdata_r <= prdata_nxt;
    end
  end
endmodule : latency_controller

// *** latency_device.sv ***
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// How it works
// - 16-beat write: aligned start, beats ascend 0..F
// - 32-beat write: aligned start, beats ascend 0..1F
// - device takes column bits 1:0 as zero
// - controller sends column bits 3:2 zero on writes
// - read latency table, inversion off; default code 0
// - read latency table, inversion on
// - write latency table set A; default code 0
// - write latency table set B
// - bit 6 picks write latency set
// - leveling bit holds register-write state until cleared
// - controller issues only clearing write while leveling
// - commands reach the write-select set-point copy
// - operation uses the operating-select copy only
// - latency register lives at address 02h
// - read inversion is io_config bit 6, default off
module latency_device
  import latency_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  mode_link_if.device  link,
  output logic [5:0]   read_latency,
  output logic [5:0]   write_latency,
  output logic         write_latency_set_select,
  output logic         write_leveling,
  output logic [5:0]   read_to_precharge_delay,
  output logic [COL_W-1:0] beat_addr,
  output logic         beat_strobe
);
  // burst sequencer: idle and running differ in one bit
  typedef enum logic [1:0] {
    BURST_IDLE = 2'b00,
    BURST_RUN  = 2'b01
  } burst_state_t;

  // set-point copies as seen by commands and by operation
  logic [7:0]       lat_rd;
  logic [7:0]       lat_op;
  logic [7:0]       io_rd;
  logic [7:0]       io_op;
  // set-point control register
  logic [7:0]       sp_r;
  logic [7:0]       sp_nxt;
  // command decode
  logic             cmd_refused;
  logic             lat_we;
  logic             io_we;
  // readback answer
  logic [7:0]       rdata_r;
  logic [7:0]       rdata_nxt;
  logic             rvalid_r;
  logic             rvalid_nxt;
  logic             err_r;
  logic             err_nxt;
  // write burst sequencer
  burst_state_t     burst_state_r;
  burst_state_t     burst_state_nxt;
  logic [COL_W-1:0] base_r;
  logic [COL_W-1:0] base_nxt;
  logic [4:0]       beat_r;
  logic [4:0]       beat_nxt;
  logic [5:0]       left_r;
  logic [5:0]       left_nxt;

  // shared decode: the only command that gets through while leveling
  function automatic logic is_latency_write(input cmd_t       c,
                                            input logic [5:0] a);
    return (c == CMD_MRW) && (a == LATENCY_CONFIG_MA);
  endfunction : is_latency_write

  // the start column is forced onto the burst boundary; the bits below it
  // are either never sent or must arrive as zero
  function automatic logic [COL_W-1:0] burst_base(input logic [COL_W-1:0] c,
                                                  input logic             b32);
    logic [COL_W-1:0] v;
    v = b32 ? {c[COL_W-1:5], 5'h00} : {c[COL_W-1:4], 4'h0};
    return v;
  endfunction : burst_base

  // beats per burst
  function automatic logic [5:0] burst_len(input logic b32);
    return b32 ? BURST32 : BURST16;
  endfunction : burst_len

  // while leveling every command but the clearing latency write is refused
  assign cmd_refused = write_leveling && (link.cmd != CMD_NONE) &&
                       !is_latency_write(link.cmd, link.ma);
  // the latency copy stays writable while leveling, or the bit could never clear
  assign lat_we = is_latency_write(link.cmd, link.ma);
  assign io_we  = !cmd_refused && (link.cmd == CMD_MRW) && (link.ma == IO_CONFIG_MA);

  set_point_pair #(.RESET_VALUE(LATENCY_RESET)) u_latency (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (lat_we),
    .wr_data (link.wdata),
    .wr_sel  (sp_r[WRITE_SET_POINT_SELECT_BIT]),
    .op_sel  (sp_r[OPERATING_SET_POINT_SELECT_BIT]),
    .rd_data (lat_rd),
    .op_data (lat_op)
  );

  set_point_pair #(.RESET_VALUE(IO_CONFIG_RESET)) u_io (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (io_we),
    .wr_data (link.wdata),
    .wr_sel  (sp_r[WRITE_SET_POINT_SELECT_BIT]),
    .op_sel  (sp_r[OPERATING_SET_POINT_SELECT_BIT]),
    .rd_data (io_rd),
    .op_data (io_op)
  );

  // latencies decode from the operating copy only
  assign read_latency  = read_latency_of(lat_op[RL_LSB+:3], io_op[RDINV_BIT]);
  assign write_latency = write_latency_of(lat_op[WL_LSB+:3], lat_op[WLS_BIT]);
  assign write_latency_set_select = lat_op[WLS_BIT];
  assign write_leveling = lat_op[WRLEV_BIT];
  // only the default code's value is known; other codes hold the default
  assign read_to_precharge_delay = RTP_DEFAULT;

  assign link.rdata   = rdata_r;
  assign link.rvalid  = rvalid_r;
  assign link.cmd_err = err_r;
  assign beat_addr    = base_r | COL_W'(beat_r);
  assign beat_strobe  = (burst_state_r == BURST_RUN);

  // set-point control: bit 6 picks the copy that commands reach, bit 7 the
  // copy that runs; a refused command leaves it untouched
  always_comb begin
    sp_nxt = sp_r;
    if (!cmd_refused && (link.cmd == CMD_MRW) && (link.ma == SET_POINT_MA)) begin
      sp_nxt = link.wdata;
    end
  end

  // async reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= SET_POINT_RESET;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // readback and refusal answers are one-cycle pulses, one cycle after the
  // command; the controller must catch them in that cycle
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    err_nxt    = cmd_refused;
    if (!cmd_refused && (link.cmd == CMD_MRR)) begin
      rvalid_nxt = 1'b1;
      case (link.ma)
        LATENCY_CONFIG_MA: rdata_nxt = lat_rd;
        IO_CONFIG_MA:      rdata_nxt = io_rd;
        SET_POINT_MA:      rdata_nxt = sp_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  // async reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r    <= err_nxt;
    end
  end

  // write burst: one beat a cycle in ascending order; a new write restarts
  // the count, since nothing queues a second burst behind the first
  always_comb begin
    burst_state_nxt = burst_state_r;
    base_nxt        = base_r;
    beat_nxt        = beat_r;
    left_nxt        = left_r;
    if (burst_state_r == BURST_RUN) begin
      beat_nxt = beat_r + 5'd1;
      left_nxt = left_r - 6'd1;
      if (left_r == 6'h01) begin
        burst_state_nxt = BURST_IDLE;
      end
    end
    if (!cmd_refused && (link.cmd == CMD_WRITE)) begin
      // low bits dropped: alignment is the controller's duty
      base_nxt        = burst_base(link.col, link.bl32);
      beat_nxt        = 5'h00;
      left_nxt        = burst_len(link.bl32);
      burst_state_nxt = BURST_RUN;
    end
  end

  // async reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_state_r <= BURST_IDLE;
      base_r        <= '0;
      beat_r        <= 5'h00;
      left_r        <= 6'h00;
    end else begin
      burst_state_r <= burst_state_nxt;
      base_r        <= base_nxt;
      beat_r        <= beat_nxt;
      left_r        <= left_nxt;
    end
  end
endmodule : latency_device

// *** latency_link_checker.sv ***
`timescale 1ns/1ps
// watches the command link between the controller and the device
module latency_link_checker
  import latency_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [1:0]        cmd,
  input wire logic [5:0]        ma,
  input wire logic [7:0]        wdata,
  input wire logic [9:0]        col,
  input wire logic              bl32,
  input wire logic              rvalid,
  input wire logic              cmd_err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a register read is answered exactly one cycle later, and only a read is
  AST_RVALID_ON_READ: assert property (cmd == CMD_MRR |=> rvalid)
    else $error("register read got no answer");
  AST_RVALID_CAUSE: assert property (rvalid |-> $past(cmd) == CMD_MRR)
    else $error("read answer without a read");
  AST_RVALID_PULSE: assert property (rvalid |=> !rvalid)
    else $error("read answer held too long");
  AST_MRW_QUIET: assert property (cmd == CMD_MRW |=> !rvalid)
    else $error("register write produced read data");
  // commands stand one cycle so the device never sees a repeat
  AST_CMD_ONE_CYCLE: assert property (cmd != CMD_NONE |=> cmd == CMD_NONE)
    else $error("command held past one cycle");
  AST_WRITE_COL_LOW: assert property (cmd == CMD_WRITE |-> col[3:0] == 4'h0)
    else $error("write column low bits not zero");
  AST_WRITE_ALIGN32: assert property (cmd == CMD_WRITE && bl32 |-> col[4:0] == 5'h00)
    else $error("32-beat write start not aligned");
  // the clearing write must always be let through while leveling
  AST_LAT_WRITE_OK: assert property (cmd == CMD_MRW && ma == LATENCY_CONFIG_MA |=> !cmd_err)
    else $error("latency write flagged illegal");
  AST_ERR_CAUSE: assert property (cmd_err |-> $past(cmd) != CMD_NONE)
    else $error("error pulse without a command");

  C_BURST32: cover property (cmd == CMD_WRITE && bl32);
  C_READ: cover property (rvalid);
  C_LEVEL: cover property (cmd == CMD_MRW && ma == LATENCY_CONFIG_MA && wdata[7]);
endmodule : latency_link_checker

// *** latency_pkg.sv ***
package latency_pkg;

  // mode-register address space and the latency register location
  localparam int          MA_W              = 6;
  localparam logic [5:0]  LATENCY_CONFIG_MA = 6'h02;
  localparam logic [5:0]  IO_CONFIG_MA      = 6'h03;
  localparam logic [5:0]  SET_POINT_MA      = 6'h0D;

  // field positions in latency_config, io_config and the set-point register
  localparam int RL_LSB     = 0;
  localparam int WL_LSB     = 3;
  localparam int WLS_BIT    = 6;
  localparam int WRLEV_BIT  = 7;
  localparam int RDINV_BIT  = 6;
  localparam int WRITE_SET_POINT_SELECT_BIT = 6;
  localparam int OPERATING_SET_POINT_SELECT_BIT = 7;

  // reset values
  localparam logic [7:0] LATENCY_RESET   = 8'h00;
  localparam logic [7:0] IO_CONFIG_RESET = 8'h00;
  localparam logic [7:0] SET_POINT_RESET = 8'h00;

  // read-to-precharge delay that goes with the default read latency code
  localparam logic [5:0] RTP_DEFAULT = 6'h08;

  // burst geometry
  localparam int          COL_W    = 10;
  localparam logic [5:0]  BURST16  = 6'h10;
  localparam logic [5:0]  BURST32  = 6'h20;

  // controller command codes
  typedef enum logic [1:0] {
    CMD_NONE  = 2'b00,
    CMD_MRW   = 2'b01,
    CMD_MRR   = 2'b11,
    CMD_WRITE = 2'b10
  } cmd_t;

  // apb register map of the controller
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] ADDR_OFF   = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] LAT_OFF    = 8'h0C;

  // latency lookups: code to clocks
  function automatic logic [5:0] read_latency_of(input logic [2:0] code, input logic inv);
    logic [5:0] v;
    v = 6'h00;
    case (code)
      3'd0: v = 6'd6;
      3'd1: v = inv ? 6'd12 : 6'd10;
      3'd2: v = inv ? 6'd16 : 6'd14;
      3'd3: v = inv ? 6'd22 : 6'd20;
      3'd4: v = inv ? 6'd28 : 6'd24;
      3'd5: v = inv ? 6'd32 : 6'd28;
      3'd6: v = inv ? 6'd36 : 6'd32;
      default: v = inv ? 6'd40 : 6'd36;
    endcase
    return v;
  endfunction : read_latency_of

  function automatic logic [5:0] write_latency_of(input logic [2:0] code, input logic set_b);
    logic [5:0] v;
    v = 6'h00;
    case (code)
      3'd0: v = 6'd4;
      3'd1: v = set_b ? 6'd8  : 6'd6;
      3'd2: v = set_b ? 6'd12 : 6'd8;
      3'd3: v = set_b ? 6'd18 : 6'd10;
      3'd4: v = set_b ? 6'd22 : 6'd12;
      3'd5: v = set_b ? 6'd26 : 6'd14;
      3'd6: v = set_b ? 6'd30 : 6'd16;
      default: v = set_b ? 6'd34 : 6'd18;
    endcase
    return v;
  endfunction : write_latency_of

endpackage : latency_pkg

// *** mode_link_if.sv ***
`timescale 1ns/1ps
interface mode_link_if;
  import latency_pkg::*;
  cmd_t        cmd;
  logic [5:0]  ma;
  logic [7:0]  wdata;
  logic [COL_W-1:0] col;
  logic        bl32;
  logic        beat_valid;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        cmd_err;

  modport device (
    input  cmd, ma, wdata, col, bl32, beat_valid,
    output rdata, rvalid, cmd_err
  );
  modport controller (
    output cmd, ma, wdata, col, bl32, beat_valid,
    input  rdata, rvalid, cmd_err
  );
endinterface : mode_link_if

// *** set_point_pair.sv ***
`timescale 1ns/1ps
// two set-point copies of one 8-bit mode register
module set_point_pair
  import latency_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_sel,
  input  wire logic       op_sel,
  output logic [7:0]      rd_data,
  output logic [7:0]      op_data
);
  logic [7:0] copy_r [2];
  logic [7:0] copy_nxt [2];

  // only the copy picked by the write select changes
  always_comb begin
    copy_nxt[0] = copy_r[0];
    copy_nxt[1] = copy_r[1];
    if (wr_en) begin
      copy_nxt[wr_sel] = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      copy_r[0] <= RESET_VALUE;
      copy_r[1] <= RESET_VALUE;
    end else begin
      copy_r[0] <= copy_nxt[0];
      copy_r[1] <= copy_nxt[1];
    end
  end

  assign rd_data = copy_r[wr_sel];
  assign op_data = copy_r[op_sel];
endmodule : set_point_pair

// *** write_burst_and_latency_mode_reg_tb.sv ***
`timescale 1ns/1ps
// apb in, device latency outputs and write beats out, against a bench model
module write_burst_and_latency_mode_reg_tb;
  import latency_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd, r;
  logic [5:0]       read_latency, write_latency, read_to_precharge_delay;
  logic             write_latency_set_select, write_leveling, beat_strobe;
  logic [COL_W-1:0] beat_addr;
  int               err_total = 0;
  int               cmp_count = 0;
  int               seed = 4367;
  int               lat[2], io[2], wsel, osel;
  int               rl0[8] = '{6, 10, 14, 20, 24, 28, 32, 36};
  int               rl1[8] = '{6, 12, 16, 22, 28, 32, 36, 40};
  int               wla[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
  int               wlb[8] = '{4, 8, 12, 18, 22, 26, 30, 34};

  mode_link_if mode_link_if_inst ();
  latency_device latency_device_inst (.pclk(pclk), .presetn(presetn), .link(mode_link_if_inst),
    .read_latency(read_latency), .write_latency(write_latency),
    .write_latency_set_select(write_latency_set_select), .write_leveling(write_leveling),
    .read_to_precharge_delay(read_to_precharge_delay), .beat_addr(beat_addr),
    .beat_strobe(beat_strobe));
  latency_controller latency_controller_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(mode_link_if_inst));
  latency_link_checker latency_link_checker_inst (.pclk(pclk), .presetn(presetn),
    .cmd(mode_link_if_inst.cmd), .ma(mode_link_if_inst.ma), .wdata(mode_link_if_inst.wdata),
    .col(mode_link_if_inst.col), .bl32(mode_link_if_inst.bl32),
    .rvalid(mode_link_if_inst.rvalid), .cmd_err(mode_link_if_inst.cmd_err));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", s, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // one apb transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
  endtask : apb

  // outputs follow the operating copy only
  task automatic check_out;
    int v;
    int inv;
    v = lat[osel];
    inv = (io[osel] >> 6) & 1;
    chk("read_latency", inv ? rl1[v & 7] : rl0[v & 7], read_latency);
    chk("write_latency", ((v >> 6) & 1) ? wlb[(v >> 3) & 7] : wla[(v >> 3) & 7],
        write_latency);
    chk("set_select", (v >> 6) & 1, write_latency_set_select);
    chk("write_leveling", (v >> 7) & 1, write_leveling);
    chk("precharge_delay", 8, read_to_precharge_delay);
  endtask : check_out

  // register write: the model updates the copy picked by the write select
  task automatic register_write_cmd(input logic [5:0] ma, input logic [7:0] d);
    apb(1'b1, ADDR_OFF, {16'h0000, d, 2'b00, ma});
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    if (ma == LATENCY_CONFIG_MA) lat[wsel] = d;
    if (ma == IO_CONFIG_MA) io[wsel] = d;
    if (ma == SET_POINT_MA) begin
      wsel = d[6];
      osel = d[7];
    end
    repeat (3) @(posedge pclk);
    check_out();
  endtask : register_write_cmd

  // status is registered, so the second read shows the current value
  task automatic rd_status(input logic [5:0] ma, input logic [1:0] cmd);
    if (cmd != 2'b00) apb(1'b1, ADDR_OFF, {26'h0, ma});
    if (cmd != 2'b00) apb(1'b1, CTRL_OFF, {30'h0, cmd});
    apb(1'b0, STATUS_OFF, 32'h0);
    apb(1'b0, STATUS_OFF, 32'h0);
  endtask : rd_status

  // write burst from a random column; low column bits must be dropped
  task automatic burst(input logic b32);
    logic [5:0]       c;
    logic [COL_W-1:0] base;
    int               n;
    r = $random(seed);
    c = r[5:0] | {5'h00, b32};
    base = b32 ? {c[5:1], 5'h00} : {c, 4'h0};
    apb(1'b1, ADDR_OFF, {6'h00, c, 20'h0_0000});
    apb(1'b1, CTRL_OFF, {29'h0, b32, 2'b10});
    n = 0;
    while (beat_strobe !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 10) begin
      err_total++;
      report_and_stop();
    end
    for (int k = 0; k < (b32 ? 32 : 16); k++) begin
      chk("beat_addr", base + k, beat_addr);
      chk("beat_strobe", 1, beat_strobe);
      @(posedge pclk);
    end
    chk("beat_strobe", 0, beat_strobe);
  endtask : burst

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check_out();
    rd_status(LATENCY_CONFIG_MA, 2'b11);
    chk("read_data", 0, rd[7:0]);
    // every code of both tables; the io filler bits are random
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      register_write_cmd(IO_CONFIG_MA, {r[7], i[3] ^ i[0], r[5:0]});
      register_write_cmd(LATENCY_CONFIG_MA, {1'b0, i[3], ~i[2:0], i[2:0]});
      rd_status(LATENCY_CONFIG_MA, 2'b11);
      chk("read_data", lat[wsel], rd[7:0]);
    end
    // the inactive copy changes without any effect
    register_write_cmd(SET_POINT_MA, 8'h40);
    register_write_cmd(LATENCY_CONFIG_MA, 8'h5B);
    register_write_cmd(SET_POINT_MA, 8'h80);
    rd_status(LATENCY_CONFIG_MA, 2'b11);
    chk("read_data", lat[0], rd[7:0]);
    register_write_cmd(SET_POINT_MA, 8'h00);
    // leveling: a read is refused until the clearing write
    register_write_cmd(LATENCY_CONFIG_MA, 8'h80);
    rd_status(IO_CONFIG_MA, 2'b11);
    chk("leveling_status", 2'b11, rd[9:8]);
    check_out();
    register_write_cmd(LATENCY_CONFIG_MA, 8'h00);
    apb(1'b1, STATUS_OFF, 32'h0);
    rd_status(IO_CONFIG_MA, 2'b00);
    chk("leveling_status", 2'b00, rd[9:8]);
    burst(1'b0);
    burst(1'b1);
    // unmapped offset is refused, the spare word reads zero
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", 1, slv);
    apb(1'b0, LAT_OFF, 32'h0);
    apb(1'b0, LAT_OFF, 32'h0);
    chk("spare_word", 0, rd);
    chk("pslverr", 0, slv);
    report_and_stop();
  end
endmodule : write_burst_and_latency_mode_reg_tb
